// ==== inc/btm_pkg.sv ====
/*
 Package for the bus transceiver mode register bank: register indices,
 field positions, reset and fail-safe values, mode encodings.
 Assumes 8-bit registers addressed by a 7-bit register index.
*/
package btm_pkg;
    localparam int          ADDR_W          = 7;
    localparam int          DATA_W          = 8;
    localparam logic [6:0]  ADDR_BUS_CTRL_P = 7'h04;
    localparam logic [6:0]  ADDR_BUS_CTRL_S = 7'h05;
    localparam logic [6:0]  ADDR_WAKE_INT   = 7'h06;
    localparam logic [6:0]  ADDR_WAKE_EXT   = 7'h07;

    // field positions, primary register
    localparam int          P_FLASH         = 7;
    localparam int          P_LSM           = 6;
    localparam int          P_TXD_TO        = 5;
    localparam int          P_FIRST_LIN_MODE_FIELD_HI       = 4;
    localparam int          P_FIRST_LIN_MODE_FIELD_LO       = 3;
    localparam int          P_SWK           = 2;
    localparam int          P_CAN_HI        = 1;
    localparam int          P_CAN_LO        = 0;
    // field positions, secondary register and external wake register
    localparam int          S_PEAK          = 5;
    localparam int          S_SECOND_LIN_MODE_FIELD_HI       = 1;
    localparam int          S_SECOND_LIN_MODE_FIELD_LO       = 0;
    localparam int          X_INT_GLOBAL    = 7;

    localparam logic [7:0]  RST_BUS_CTRL_P  = 8'h20;
    localparam logic [7:0]  RST_BUS_CTRL_S  = 8'h00;
    localparam logic [7:0]  RST_WAKE_INT    = 8'h00;
    localparam logic [7:0]  RST_WAKE_EXT    = 8'h07;
    localparam logic [7:0]  MASK_BUS_CTRL_S = 8'h23;
    localparam logic [7:0]  MASK_WAKE_INT   = 8'hC4;
    localparam logic [7:0]  MASK_WAKE_EXT   = 8'hA7;
    // fail-safe forcing: keep bits given by the keep mask, force the rest to the fail-safe value
    localparam logic [7:0]  FS_KEEP_P       = 8'hE0;
    localparam logic [7:0]  FS_VAL_P        = 8'h09;
    localparam logic [7:0]  FS_KEEP_X       = 8'hA0;
    localparam logic [7:0]  FS_VAL_X        = 8'h07;

    localparam logic [1:0]  MODE_OFF        = 2'h0;
    localparam logic [1:0]  MODE_WAKE       = 2'h1;
    localparam logic [1:0]  MODE_RXONLY     = 2'h2;
    localparam logic [1:0]  MODE_NORMAL     = 2'h3;

    typedef enum logic [3:0] {
        BTM_IDLE  = 4'h1,
        BTM_ADDR  = 4'h2,
        BTM_DATA  = 4'h4,
        BTM_DONE  = 4'h8
    } btm_spi_st_t;
endpackage

// ==== src/btm_mode_regs.sv ====
/*
 Bus transceiver mode registers behind a 16-bit SPI slave, with automatic
 CAN mode changes on Sleep entry and CAN/LIN mode changes on Fail-Safe entry; Stop entry changes nothing.
 Assumes a mode controller delivers one-cycle entry pulses on clk, and
 that the SPI master runs sck far below clk (pins are synchronised).
*/
module btm_mode_regs
    import btm_pkg::*;
(
    input  wire logic        clk,               // 250 MHz system clock
    input  wire logic        rst_n,             // async reset, active low
    input  wire logic        ce,                // clock enable
    input  wire logic        spi_csn_n,         // SPI chip select, active low
    input  wire logic        spi_sck,           // SPI clock pin
    input  wire logic        spi_sdi,           // SPI data in
    output logic             spi_sdo,           // SPI data out
    output logic             spi_sdo_oe,        // SPI data out enable
    input  wire logic        mode_init,         // device in init mode
    input  wire logic        mode_normal,       // device in normal mode
    input  wire logic        mode_stop,         // device in stop mode
    input  wire logic        sleep_entry,       // pulse: sleep entered
    input  wire logic        stop_entry,        // pulse: stop entered
    input  wire logic        failsafe_entry,    // pulse: fail-safe by failure
    input  wire logic        restart_entry,     // pulse: restart entered
    input  wire logic        system_error_flag, // system error status
    input  wire logic        wake_event,        // a wake source fired
    input  wire logic        status_event,      // any other status bit set
    output logic             lin_flash_mode,    // LIN slope control off
    output logic             lin_low_slope_select, // LIN low-slope mode
    output logic             lin_tx_timeout_enable, // TXD time-out on
    output logic [1:0]       first_lin_mode_field,  // LIN 1 mode
    output logic [2:0]       can_mode,          // CAN mode incl selective wake
    output logic [1:0]       second_lin_mode_field, // LIN 2 mode
    output logic             regulator_peak_threshold_select, // peak level
    output logic             int_req            // interrupt request
);
    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       srst_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign srst_n = rst_sync_r[1];

    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic       sck_d_r;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            pin_s1_r <= 3'b001;
            pin_s2_r <= 3'b001;
            sck_d_r  <= 1'b0;
        end else if (ce) begin
            pin_s1_r <= {spi_sdi, spi_sck, spi_csn_n};
            pin_s2_r <= pin_s1_r;
            sck_d_r  <= pin_s2_r[1];
        end
    end

    logic csn_s, sck_s, sdi_s, sck_rise, sck_fall;
    assign csn_s    = pin_s2_r[0];
    assign sck_s    = pin_s2_r[1];
    assign sdi_s    = pin_s2_r[2];
    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;

    // ----------------------------------------------------------------
    // SPI frame: 7-bit address, write flag, 8 data bits (msb first)
    // ----------------------------------------------------------------
    btm_spi_st_t st_r;
    logic [4:0]  bitcnt_r;
    logic [15:0] shift_r;
    logic [7:0]  tx_r;
    logic [7:0]  rdata;
    logic [4*8-1:0] qall;
    logic        frame_end;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            st_r     <= BTM_IDLE;
            bitcnt_r <= 5'h00;
            shift_r  <= 16'h0000;
        end else if (ce) begin
            case (st_r)
                BTM_IDLE: begin
                    bitcnt_r <= 5'h00;
                    if (!csn_s) begin
                        st_r <= BTM_ADDR;
                    end
                end
                BTM_ADDR, BTM_DATA: begin
                    if (csn_s) begin
                        // five count bits so that the sixteenth bit does not wrap to zero
                        st_r <= (bitcnt_r == 5'h10 && st_r == BTM_DATA) ? BTM_DONE
                                                                        : BTM_IDLE;
                    end else if (sck_rise) begin
                        shift_r  <= {shift_r[14:0], sdi_s};
                        bitcnt_r <= bitcnt_r + 5'h01;
                        if (bitcnt_r == 5'h07) begin
                            st_r <= BTM_DATA;
                        end
                    end
                end
                BTM_DONE: begin
                    st_r <= BTM_IDLE;
                end
                default: begin
                    st_r <= BTM_IDLE;
                end
            endcase
        end
    end
    // frames are taken only as whole 16-bit words at chip-select release
    assign frame_end = (st_r == BTM_DONE);

    logic [6:0] f_addr;
    logic       f_wr;
    logic [7:0] f_data;
    assign f_addr = shift_r[15:9];
    assign f_wr   = shift_r[8];
    assign f_data = shift_r[7:0];

    // read data for the addressed register launches msb first on sck falls
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            tx_r       <= 8'h00;
            spi_sdo    <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (ce) begin
            spi_sdo_oe <= ~csn_s;
            if (st_r == BTM_DATA && bitcnt_r == 5'h08 && sck_fall) begin
                tx_r    <= {rdata[6:0], 1'b0};
                spi_sdo <= rdata[7];
            end else if (st_r == BTM_DATA && sck_fall) begin
                tx_r    <= {tx_r[6:0], 1'b0};
                spi_sdo <= tx_r[7];
            end
        end
    end

    function automatic logic [1:0] sel_of(input logic [6:0] a);
        sel_of = a[1:0];
    endfunction

    // ----------------------------------------------------------------
    // next register values: host writes, then automatic mode changes
    // ----------------------------------------------------------------
    logic [7:0] cur_p, cur_s, cur_i, cur_x;
    logic [7:0] nxt_p, nxt_s, nxt_i, nxt_x;
    logic [3:0] we;
    assign cur_p = qall[7:0];
    assign cur_s = qall[15:8];
    assign cur_i = qall[23:16];
    assign cur_x = qall[31:24];

    logic hit_p, hit_s, hit_i, hit_x;
    always_comb begin
        hit_p = 1'b0;
        hit_s = 1'b0;
        hit_i = 1'b0;
        hit_x = 1'b0;
        if (f_addr == ADDR_BUS_CTRL_P) begin
            hit_p = frame_end & f_wr;
        end else if (f_addr == ADDR_BUS_CTRL_S) begin
            hit_s = frame_end & f_wr;
        end else if (f_addr == ADDR_WAKE_INT) begin
            hit_i = frame_end & f_wr;
        end else if (f_addr == ADDR_WAKE_EXT) begin
            hit_x = frame_end & f_wr;
        end
    end

    always_comb begin
        nxt_p = hit_p ? f_data : cur_p;
        nxt_s = cur_s;
        nxt_i = hit_i ? (f_data & MASK_WAKE_INT) : cur_i;
        nxt_x = hit_x ? (f_data & MASK_WAKE_EXT) : cur_x;
        if (hit_s) begin
            nxt_s = f_data & MASK_BUS_CTRL_S;
            if (!(mode_init || mode_normal)) begin
                nxt_s[S_PEAK] = cur_s[S_PEAK];
            end
        end
        // sleep demotes receive-only/normal to wake; bit 2 never touched
        if (sleep_entry && !system_error_flag && nxt_p[P_CAN_HI]) begin
            nxt_p[P_CAN_HI:P_CAN_LO] = MODE_WAKE;
        end
        // stop entry leaves every CAN mode as programmed
        if (stop_entry) begin
            nxt_p = nxt_p;
        end
        if (failsafe_entry) begin
            nxt_p = (cur_p & FS_KEEP_P) | FS_VAL_P;
            nxt_x = (cur_x & FS_KEEP_X) | FS_VAL_X;
        end
        // restart: bits 7:5 kept; mode fields left as programmed
        if (restart_entry) begin
            nxt_p[P_FLASH:P_TXD_TO] = cur_p[P_FLASH:P_TXD_TO];
        end
    end
    assign we = {hit_x | failsafe_entry, hit_i, hit_s,
                 hit_p | sleep_entry | failsafe_entry};

    btm_regfile u_regs (
        .clk   (clk),
        .rst_n (srst_n),
        .ce    (ce),
        .we    (we),
        .wdata ({nxt_x, nxt_i, nxt_s, nxt_p}),
        // after the command byte the address sits in the low shift bits
        .raddr (sel_of(shift_r[7:1])),
        .rdata (rdata),
        .qall  (qall)
    );

    // ----------------------------------------------------------------
    // decoded control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            lin_flash_mode        <= RST_BUS_CTRL_P[P_FLASH];
            lin_low_slope_select  <= RST_BUS_CTRL_P[P_LSM];
        end else if (ce && frame_end) begin
            // next value, so the new setting acts at the release itself
            lin_flash_mode        <= nxt_p[P_FLASH];
            lin_low_slope_select  <= nxt_p[P_LSM];
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            lin_tx_timeout_enable           <= RST_BUS_CTRL_P[P_TXD_TO];
            first_lin_mode_field            <= MODE_OFF;
            can_mode                        <= 3'h0;
            second_lin_mode_field           <= MODE_OFF;
            regulator_peak_threshold_select <= RST_BUS_CTRL_S[S_PEAK];
        end else if (ce) begin
            lin_tx_timeout_enable           <= cur_p[P_TXD_TO];
            first_lin_mode_field            <= cur_p[P_FIRST_LIN_MODE_FIELD_HI:P_FIRST_LIN_MODE_FIELD_LO];
            can_mode                        <= cur_p[P_SWK:P_CAN_LO];
            second_lin_mode_field           <= cur_s[S_SECOND_LIN_MODE_FIELD_HI:S_SECOND_LIN_MODE_FIELD_LO];
            regulator_peak_threshold_select <= cur_s[S_PEAK];
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            int_req <= 1'b0;
        end else if (ce) begin
            int_req <= wake_event | (cur_x[X_INT_GLOBAL] & status_event);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_sleep_demote: assert property (@(posedge clk) disable iff (!srst_n)
        ce && sleep_entry && !system_error_flag && !failsafe_entry && !hit_p
        && cur_p[P_CAN_HI] |=> cur_p[P_CAN_HI:P_CAN_LO] == MODE_WAKE)
        else $error("sleep entry did not demote CAN");
    a_swk_kept: assert property (@(posedge clk) disable iff (!srst_n)
        ce && !hit_p && !failsafe_entry |=> $stable(cur_p[P_SWK]))
        else $error("selective wake bit changed by device");
    a_failsafe_val: assert property (@(posedge clk) disable iff (!srst_n)
        ce && failsafe_entry |=> cur_p[4:0] == FS_VAL_P[4:0] && cur_x[2:0] == 3'h7)
        else $error("fail-safe values not forced");
    a_peak_locked: assert property (@(posedge clk) disable iff (!srst_n)
        ce && mode_stop && !mode_init && !mode_normal |=> $stable(cur_s[S_PEAK]))
        else $error("peak threshold changed in stop");
    a_resv_zero: assert property (@(posedge clk) disable iff (!srst_n)
        (cur_s & ~MASK_BUS_CTRL_S) == 8'h00)
        else $error("reserved secondary bits set");
    a_stop_keep: assert property (@(posedge clk) disable iff (!srst_n)
        ce && stop_entry && !sleep_entry && !failsafe_entry && !hit_p
        |=> $stable(cur_p))
        else $error("stop entry altered CAN mode");
    a_flash_csn: assert property (@(posedge clk) disable iff (!srst_n)
        ce && !frame_end |=> $stable(lin_flash_mode))
        else $error("flash mode changed outside frame end");
    a_can_follow: assert property (@(posedge clk) disable iff (!srst_n)
        ce ##1 ce |-> can_mode == $past(cur_p[P_SWK:P_CAN_LO]))
        else $error("CAN mode output not following register");
endmodule

// ==== src/btm_regfile.sv ====
/*
 Four-word register store for the mode bank; read data registered.
 Assumes the caller resolves all write priorities before writing.
*/
module btm_regfile
    import btm_pkg::*;
(
    input  wire logic              clk,      // system clock
    input  wire logic              rst_n,    // synchronised reset
    input  wire logic              ce,       // clock enable
    input  wire logic [3:0]        we,       // per-register write strobes
    input  wire logic [4*8-1:0]    wdata,    // packed write data
    input  wire logic [1:0]        raddr,    // read select
    output logic      [7:0]        rdata,    // registered read data
    output logic      [4*8-1:0]    qall      // current register values
);
    localparam logic [4*8-1:0] RST_ALL = {RST_WAKE_EXT, RST_WAKE_INT,
                                          RST_BUS_CTRL_S, RST_BUS_CTRL_P};
    logic [7:0] mem_r [4];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem_r[i] <= RST_ALL[i*8 +: 8];
            end
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (we[i]) begin
                    mem_r[i] <= wdata[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= mem_r[raddr];
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            qall[i*8 +: 8] = mem_r[i];
        end
    end
endmodule

// ==== tb/btm_spi_host.sv ====
/*
 Host microcontroller model: 16-bit SPI master for the mode register bank.
 Assumes CPOL 0 framing with address, write bit and data sent msb first.
 Assumes the device synchronises its pins to clk.
*/
module btm_spi_host (
    input  wire logic       clk,        // system clock
    output logic            spi_csn_n,  // chip select, active low
    output logic            spi_sck,    // serial clock, still outside frames
    output logic            spi_sdi,    // data to the device
    input  wire logic       spi_sdo,    // data from the device
    input  wire logic       spi_sdo_oe, // device drives spi_sdo
    output logic [7:0]      rd_data,    // data of the last frame, read or write
    output logic            rd_valid    // one-cycle read result strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    // half sck period in clk cycles, twice the device minimum
    localparam int HALF = 8;

    logic toggle_r = 1'b0;
    logic sdo_line;

    // released line shows a changing pattern, never a stale bit
    always @(posedge clk) toggle_r <= ~toggle_r;
    assign sdo_line = spi_sdo_oe ? spi_sdo : toggle_r;

    initial begin
        spi_csn_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
        rd_data = 8'h00;
        rd_valid = 1'b0;
    end

    // -------------------------------------------------------------
    // one frame; gap afterwards keeps chip select high long enough
    // -------------------------------------------------------------
    task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata);
        logic [15:0] sh;
        logic [7:0]  rd;
        sh = {addr, wr, wdata};
        rd = 8'h00;
        @(negedge clk) spi_csn_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = sh[i];
            repeat (HALF) @(negedge clk);
            if (i < 8) rd = {rd[6:0], sdo_line};
            spi_sck = 1'b1;
            repeat (HALF) @(negedge clk);
            spi_sck = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        spi_csn_n = 1'b1;
        rd_data = rd;
        rd_valid = ~wr;
        @(negedge clk) rd_valid = 1'b0;
        repeat (12) @(negedge clk);
    endtask
endmodule

// ==== tb/tb_bus_transceiver_mode_regs.sv ====
/*
 Self-checking bench for the mode register bank, driven through the host model.
 Assumes write bit 1 marks a write and read data comes in the same frame.
*/
module tb_bus_transceiver_mode_regs
    import btm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // run needs about 18300 cycles
    localparam int LIMIT = 60000;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        mode_init = 1'b0;
    logic        mode_normal = 1'b1;
    logic        mode_stop = 1'b0;
    logic        sleep_entry = 1'b0;
    logic        stop_entry = 1'b0;
    logic        failsafe_entry = 1'b0;
    logic        restart_entry = 1'b0;
    logic        system_error_flag = 1'b0;
    logic        wake_event = 1'b0;
    logic        status_event = 1'b0;
    logic        pin_go = 1'b0;
    logic        spi_csn_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, rd_valid;
    logic        lin_flash_mode, lin_low_slope_select, lin_tx_timeout_enable;
    logic        regulator_peak_threshold_select, int_req;
    logic [1:0]  first_lin_mode_field, second_lin_mode_field;
    logic [2:0]  can_mode;
    logic [7:0]  rd_data, d, e;
    logic [11:0] rd_q[$];
    logic [11:0] pin_q[$];
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #2 clk = ~clk;

    btm_mode_regs dut (.clk(clk), .rst_n(rst_n), .ce(ce), .spi_csn_n(spi_csn_n),
        .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .mode_init(mode_init), .mode_normal(mode_normal), .mode_stop(mode_stop),
        .sleep_entry(sleep_entry), .stop_entry(stop_entry), .failsafe_entry(failsafe_entry),
        .restart_entry(restart_entry), .system_error_flag(system_error_flag),
        .wake_event(wake_event), .status_event(status_event),
        .lin_flash_mode(lin_flash_mode), .lin_low_slope_select(lin_low_slope_select),
        .lin_tx_timeout_enable(lin_tx_timeout_enable),
        .first_lin_mode_field(first_lin_mode_field), .can_mode(can_mode),
        .second_lin_mode_field(second_lin_mode_field),
        .regulator_peak_threshold_select(regulator_peak_threshold_select),
        .int_req(int_req));

    btm_spi_host host (.clk(clk), .spi_csn_n(spi_csn_n), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .rd_data(rd_data), .rd_valid(rd_valid));

    // -------------------------------------------------------------
    // verdict, comparison and monitor
    // -------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (rd_valid) cmp({4'h0, rd_data}, (rd_q.size() > 0) ? rd_q.pop_front() : 12'hFFF);
        if (pin_go) cmp({int_req, regulator_peak_threshold_select, second_lin_mode_field,
            lin_flash_mode, lin_low_slope_select, lin_tx_timeout_enable,
            first_lin_mode_field, can_mode}, (pin_q.size() > 0) ? pin_q.pop_front() : 12'hFFF);
        if (cyc == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    // -------------------------------------------------------------
    // stimulus helpers
    // -------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.xfer(a, 1'b1, v);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] v);
        rd_q.push_back({4'h0, v});
        host.xfer(a, 1'b0, 8'h00);
    endtask

    // hi holds int_req, peak select and second LIN mode
    task automatic pins(input logic [3:0] hi, input logic [7:0] prim);
        pin_q.push_back({hi, prim});
        @(negedge clk) pin_go = 1'b1;
        @(negedge clk) pin_go = 1'b0;
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        void'($urandom(32'h399C));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        pins(4'h0, RST_BUS_CTRL_P);
        rd(ADDR_BUS_CTRL_P, RST_BUS_CTRL_P);
        rd(ADDR_BUS_CTRL_S, RST_BUS_CTRL_S);
        rd(ADDR_WAKE_INT, RST_WAKE_INT);
        rd(ADDR_WAKE_EXT, RST_WAKE_EXT);
        for (int i = 0; i < 8; i++) begin
            d = {3'($urandom), 2'(i), 3'(i)};
            wr(ADDR_BUS_CTRL_P, d);
            pins(4'h0, d);
            rd(ADDR_BUS_CTRL_P, d);
        end
        rd(7'h08, d);
        mode_init = 1'b1;
        mode_normal = 1'b0;
        e = 8'($urandom) | 8'h20;
        wr(ADDR_BUS_CTRL_S, e);
        rd(ADDR_BUS_CTRL_S, e & MASK_BUS_CTRL_S);
        pins({2'b01, e[1:0]}, d);
        mode_init = 1'b0;
        mode_stop = 1'b1;
        wr(ADDR_BUS_CTRL_S, 8'hDE);
        rd(ADDR_BUS_CTRL_S, 8'h22);
        pins(4'h6, d);
        mode_stop = 1'b0;
        mode_normal = 1'b1;
        wr(ADDR_BUS_CTRL_S, 8'h01);
        rd(ADDR_BUS_CTRL_S, 8'h01);
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 8; c++) begin
                if (k == 1 && c[1:0] == 2'h3) continue;
                d = {3'($urandom), MODE_WAKE, 3'(c)};
                wr(ADDR_BUS_CTRL_P, d);
                if (k == 0) pulse(sleep_entry);
                else pulse(stop_entry);
                e = d;
                if (k == 0 && c[1]) e[1:0] = MODE_WAKE;
                rd(ADDR_BUS_CTRL_P, e);
                pins(4'h1, e);
            end
        end
        // frozen clock enable hides the entry; a system error blocks demotion
        wr(ADDR_BUS_CTRL_P, 8'h0B);
        ce = 1'b0;
        pulse(sleep_entry);
        ce = 1'b1;
        rd(ADDR_BUS_CTRL_P, 8'h0B);
        system_error_flag = 1'b1;
        pulse(sleep_entry);
        rd(ADDR_BUS_CTRL_P, 8'h0B);
        system_error_flag = 1'b0;
        wr(ADDR_WAKE_EXT, 8'h80);
        wr(ADDR_BUS_CTRL_P, 8'hFF);
        pulse(failsafe_entry);
        rd(ADDR_BUS_CTRL_P, 8'hE9);
        rd(ADDR_WAKE_EXT, 8'h87);
        pins(4'h1, 8'hE9);
        wr(ADDR_BUS_CTRL_P, 8'h6B);
        pulse(restart_entry);
        rd(ADDR_BUS_CTRL_P, 8'h6B);
        status_event = 1'b1;
        repeat (3) @(negedge clk);
        pins(4'h9, 8'h6B);
        wr(ADDR_WAKE_EXT, 8'h07);
        pins(4'h1, 8'h6B);
        wake_event = 1'b1;
        repeat (3) @(negedge clk);
        pins(4'h9, 8'h6B);
        repeat (10) @(negedge clk);
        if (rd_q.size() != 0 || pin_q.size() != 0) n_fail++;
        conclude();
    end
endmodule
